// ==== src/pidr_pkg.sv ====
// pidr_pkg: constants, register map, types and the behaviour list for the process regulator.
// assumes one 200 MHz clock and a plain register port with 32-bit words.
// Behaviour
// - Forward action: feedback below setting drives the output upward.
// - Setting and feedback are 0..100% relative values; the loop drives them equal.
// - Reverse action: feedback below setting drives the output downward.
// - Terminal function 35 inverts the configured action direction.
// - Setting and feedback readouts scale 100% to a range value, default 1000.
// - Proportional gain 100.0 maps full-scale error to maximum frequency; default 20.0.
// - Full-scale error integrates to maximum frequency over the integral time.
// - Full-scale feedback change within differential time gives maximum frequency; zero disables.
// - Negative output frequency is clamped to the reverse cut-off, default 2.00 Hz.
// - Error below the deviation limit suspends regulation; default 0.
// - Differential term is clamped to a small range, default 0.10%.
// - Setting ramps linearly over the configured 0..100% time; zero means step.
// - Feedback and output each pass a first-order filter with own time constant.
// - Gain set switchover mode: 0 none, 1 terminal, 2 automatic by error.
// - Terminal mode: function 43 off selects set one, on selects set two.
// - Automatic mode: set one below threshold one, set two above two, else interpolated.
// - At start the output holds the initial value for the hold time.
// - New output every 2 ms, rise and fall steps limited, default 1.00%.
// - With separation enabled, function 38 freezes the integral term.
// - With stop-at-limit selected, integration halts while the output is limited.
// - Feedback below loss level longer than loss time raises fault; level 0 disables.
// - At stop, option 0 stops computation and option 1 keeps computing.
package pidr_pkg;

  localparam int unsigned TICK_TIME_US  = 2000;
  localparam int unsigned CLK_FREQ_MHZ  = 200;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned CS_US         = 10000;
  localparam int unsigned DS_US         = 100000;
  localparam int unsigned TICKS_PER_CS  = CS_US / TICK_TIME_US;
  localparam int unsigned TICKS_PER_DS  = DS_US / TICK_TIME_US;
  localparam int unsigned US_PER_MS     = 1000;

  localparam logic signed [31:0] PCT_FULL  = 32'sh0000_2710;
  localparam logic signed [31:0] KP_FULL   = 32'sh0000_03e8;
  localparam logic signed [31:0] PERMILLE  = 32'sh0000_000a;
  localparam int unsigned        FRAC_BITS = 16;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_RANGE     = 8'h04;
  localparam logic [7:0] REG_KP1       = 8'h08;
  localparam logic [7:0] REG_TI1       = 8'h0c;
  localparam logic [7:0] REG_TD1       = 8'h10;
  localparam logic [7:0] REG_KP2       = 8'h14;
  localparam logic [7:0] REG_TI2       = 8'h18;
  localparam logic [7:0] REG_TD2       = 8'h1c;
  localparam logic [7:0] REG_REV_CUT   = 8'h20;
  localparam logic [7:0] REG_DEAD      = 8'h24;
  localparam logic [7:0] REG_DCLAMP    = 8'h28;
  localparam logic [7:0] REG_RAMP      = 8'h2c;
  localparam logic [7:0] REG_FB_FILT   = 8'h30;
  localparam logic [7:0] REG_OUT_FILT  = 8'h34;
  localparam logic [7:0] REG_SW_MODE   = 8'h38;
  localparam logic [7:0] REG_THR_LO    = 8'h3c;
  localparam logic [7:0] REG_THR_HI    = 8'h40;
  localparam logic [7:0] REG_INIT      = 8'h44;
  localparam logic [7:0] REG_HOLD      = 8'h48;
  localparam logic [7:0] REG_RISE      = 8'h4c;
  localparam logic [7:0] REG_FALL      = 8'h50;
  localparam logic [7:0] REG_LOSS_LVL  = 8'h54;
  localparam logic [7:0] REG_LOSS_TIME = 8'h58;
  localparam logic [7:0] REG_MAX_FREQ  = 8'h5c;
  localparam logic [7:0] REG_STATUS    = 8'h60;
  localparam logic [7:0] REG_SET_RD    = 8'h64;
  localparam logic [7:0] REG_FB_RD     = 8'h68;
  localparam logic [7:0] REG_OUT_PCT   = 8'h6c;

  localparam int unsigned CTRL_DIR      = 0;
  localparam int unsigned CTRL_RUN_STOP = 1;
  localparam int unsigned CTRL_SEP      = 2;
  localparam int unsigned CTRL_STOP_LIM = 3;
  localparam int unsigned CTRL_CLR      = 4;

  localparam logic [15:0] RST_RANGE  = 16'h03e8;
  localparam logic [15:0] RST_KP     = 16'h00c8;
  localparam logic [15:0] RST_TI     = 16'h00c8;
  localparam logic [15:0] RST_REVCUT = 16'h00c8;
  localparam logic [15:0] RST_DCLAMP = 16'h000a;
  localparam logic [15:0] RST_THR_LO = 16'h00c8;
  localparam logic [15:0] RST_THR_HI = 16'h0320;
  localparam logic [15:0] RST_STEP   = 16'h0064;
  localparam logic [15:0] RST_MAXF   = 16'h1388;

  localparam logic [1:0] SW_NONE = 2'h0;
  localparam logic [1:0] SW_TERM = 2'h1;
  localparam logic [1:0] SW_AUTO = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RUN} pidr_state_e;

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] range, kp1, ti1, td1, kp2, ti2, td2, rev_cut, dead, dclamp;
    logic [15:0] ramp, fb_filt, out_filt;
    logic [1:0]  sw_mode;
    logic [15:0] thr_lo, thr_hi, init, hold, rise, fall, loss_lvl, loss_time, max_freq;
  } pidr_cfg_s;

  typedef struct packed {
    logic dir_invert;
    logic int_pause;
    logic gain_select;
  } pidr_term_s;

endpackage

// ==== src/pidr_regulator.sv ====
// pidr_regulator: process closed-loop regulator with register port and 2 ms update tick.
// assumes setting, feedback and run come from logic on clk; terminals are asynchronous pins.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pidr_regulator #(
  parameter int unsigned TICK_CYCLES = pidr_pkg::TICK_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [7:0]          addr,
  input  wire logic [31:0]         wr_data,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [31:0]         rd_data,
  input  wire logic [15:0]         setting_in,
  input  wire logic [15:0]         feedback_in,
  input  wire logic                drive_run,
  input  wire pidr_pkg::pidr_term_s term_in,
  output logic signed [31:0]       freq_out,
  output logic                     out_valid,
  output logic                     feedback_loss_fault
);

  function automatic logic signed [31:0] s32(input logic [15:0] v);
    s32 = signed'({16'h0000, v});
  endfunction

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [31:0] filt(input logic signed [31:0] y,
                                              input logic signed [31:0] x,
                                              input logic [15:0]        tc);
    filt = y + (x - y) / (s32(tc) * $signed(32'(pidr_pkg::TICKS_PER_CS)) + 32'sh1);
  endfunction

  function automatic logic signed [31:0] lerp(input logic signed [31:0] a,
                                              input logic signed [31:0] b,
                                              input logic signed [31:0] e,
                                              input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
    lerp = (hi == lo) ? b : a + (b - a) * (e - lo) / (hi - lo);
  endfunction

  pidr_pkg::pidr_cfg_s     cfg_reg;
  pidr_pkg::pidr_term_s    sync1_reg, sync2_reg;
  pidr_pkg::pidr_state_e   state_reg;
  logic [31:0]             tick_cnt_reg;
  logic                    tick;
  logic                    run_prev_reg;
  logic [31:0]             hold_cnt_reg, loss_cnt_reg;
  logic signed [31:0]      set_eff_reg, fb_filt_reg, fb_prev_reg;
  logic signed [31:0]      i_reg, out_pct_reg, out_filt_reg;
  logic                    sat_reg;
  logic                    loss_now;
  logic                    computing;

  logic signed [31:0] set_pct, fb_pct, err, abs_err, kp, ti, td;
  logic signed [31:0] p_term, d_term, raw, lim, step_out, ramp_step, set_next, fb_next;
  logic signed [31:0] out_filt_next, freq_next, rev_lim;
  logic               dir_rev, i_freeze, in_dead, sat_next;

  // terminal pins are asynchronous
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= term_in;
      sync2_reg <= sync1_reg;
    end
  end

  // update tick every 2 ms
  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt_reg <= '0;
      tick         <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick         <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick         <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg          <= '0;
      cfg_reg.range    <= pidr_pkg::RST_RANGE;
      cfg_reg.kp1      <= pidr_pkg::RST_KP;
      cfg_reg.kp2      <= pidr_pkg::RST_KP;
      cfg_reg.ti1      <= pidr_pkg::RST_TI;
      cfg_reg.ti2      <= pidr_pkg::RST_TI;
      cfg_reg.rev_cut  <= pidr_pkg::RST_REVCUT;
      cfg_reg.dclamp   <= pidr_pkg::RST_DCLAMP;
      cfg_reg.thr_lo   <= pidr_pkg::RST_THR_LO;
      cfg_reg.thr_hi   <= pidr_pkg::RST_THR_HI;
      cfg_reg.rise     <= pidr_pkg::RST_STEP;
      cfg_reg.fall     <= pidr_pkg::RST_STEP;
      cfg_reg.max_freq <= pidr_pkg::RST_MAXF;
    end else if (wr_en) begin
      case (addr)
        pidr_pkg::REG_CTRL:      cfg_reg.ctrl      <= {1'b0, wr_data[3:0]};
        pidr_pkg::REG_RANGE:     cfg_reg.range     <= wr_data[15:0];
        pidr_pkg::REG_KP1:       cfg_reg.kp1       <= wr_data[15:0];
        pidr_pkg::REG_TI1:       cfg_reg.ti1       <= wr_data[15:0];
        pidr_pkg::REG_TD1:       cfg_reg.td1       <= wr_data[15:0];
        pidr_pkg::REG_KP2:       cfg_reg.kp2       <= wr_data[15:0];
        pidr_pkg::REG_TI2:       cfg_reg.ti2       <= wr_data[15:0];
        pidr_pkg::REG_TD2:       cfg_reg.td2       <= wr_data[15:0];
        pidr_pkg::REG_REV_CUT:   cfg_reg.rev_cut   <= wr_data[15:0];
        pidr_pkg::REG_DEAD:      cfg_reg.dead      <= wr_data[15:0];
        pidr_pkg::REG_DCLAMP:    cfg_reg.dclamp    <= wr_data[15:0];
        pidr_pkg::REG_RAMP:      cfg_reg.ramp      <= wr_data[15:0];
        pidr_pkg::REG_FB_FILT:   cfg_reg.fb_filt   <= wr_data[15:0];
        pidr_pkg::REG_OUT_FILT:  cfg_reg.out_filt  <= wr_data[15:0];
        pidr_pkg::REG_SW_MODE:   cfg_reg.sw_mode   <= wr_data[1:0];
        pidr_pkg::REG_THR_LO:    cfg_reg.thr_lo    <= wr_data[15:0];
        pidr_pkg::REG_THR_HI:    cfg_reg.thr_hi    <= wr_data[15:0];
        pidr_pkg::REG_INIT:      cfg_reg.init      <= wr_data[15:0];
        pidr_pkg::REG_HOLD:      cfg_reg.hold      <= wr_data[15:0];
        pidr_pkg::REG_RISE:      cfg_reg.rise      <= wr_data[15:0];
        pidr_pkg::REG_FALL:      cfg_reg.fall      <= wr_data[15:0];
        pidr_pkg::REG_LOSS_LVL:  cfg_reg.loss_lvl  <= wr_data[15:0];
        pidr_pkg::REG_LOSS_TIME: cfg_reg.loss_time <= wr_data[15:0];
        pidr_pkg::REG_MAX_FREQ:  cfg_reg.max_freq  <= wr_data[15:0];
        default: ;
      endcase
    end
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      case (addr)
        pidr_pkg::REG_CTRL:      rd_data <= {28'h0, cfg_reg.ctrl[3:0]};
        pidr_pkg::REG_RANGE:     rd_data <= {16'h0, cfg_reg.range};
        pidr_pkg::REG_KP1:       rd_data <= {16'h0, cfg_reg.kp1};
        pidr_pkg::REG_TI1:       rd_data <= {16'h0, cfg_reg.ti1};
        pidr_pkg::REG_TD1:       rd_data <= {16'h0, cfg_reg.td1};
        pidr_pkg::REG_KP2:       rd_data <= {16'h0, cfg_reg.kp2};
        pidr_pkg::REG_TI2:       rd_data <= {16'h0, cfg_reg.ti2};
        pidr_pkg::REG_TD2:       rd_data <= {16'h0, cfg_reg.td2};
        pidr_pkg::REG_REV_CUT:   rd_data <= {16'h0, cfg_reg.rev_cut};
        pidr_pkg::REG_DEAD:      rd_data <= {16'h0, cfg_reg.dead};
        pidr_pkg::REG_DCLAMP:    rd_data <= {16'h0, cfg_reg.dclamp};
        pidr_pkg::REG_RAMP:      rd_data <= {16'h0, cfg_reg.ramp};
        pidr_pkg::REG_FB_FILT:   rd_data <= {16'h0, cfg_reg.fb_filt};
        pidr_pkg::REG_OUT_FILT:  rd_data <= {16'h0, cfg_reg.out_filt};
        pidr_pkg::REG_SW_MODE:   rd_data <= {30'h0, cfg_reg.sw_mode};
        pidr_pkg::REG_THR_LO:    rd_data <= {16'h0, cfg_reg.thr_lo};
        pidr_pkg::REG_THR_HI:    rd_data <= {16'h0, cfg_reg.thr_hi};
        pidr_pkg::REG_INIT:      rd_data <= {16'h0, cfg_reg.init};
        pidr_pkg::REG_HOLD:      rd_data <= {16'h0, cfg_reg.hold};
        pidr_pkg::REG_RISE:      rd_data <= {16'h0, cfg_reg.rise};
        pidr_pkg::REG_FALL:      rd_data <= {16'h0, cfg_reg.fall};
        pidr_pkg::REG_LOSS_LVL:  rd_data <= {16'h0, cfg_reg.loss_lvl};
        pidr_pkg::REG_LOSS_TIME: rd_data <= {16'h0, cfg_reg.loss_time};
        pidr_pkg::REG_MAX_FREQ:  rd_data <= {16'h0, cfg_reg.max_freq};
        pidr_pkg::REG_STATUS:    rd_data <= {28'h0, sat_reg, state_reg, feedback_loss_fault};
        pidr_pkg::REG_SET_RD:    rd_data <= 32'((set_pct * s32(cfg_reg.range)) / pidr_pkg::PCT_FULL);
        pidr_pkg::REG_FB_RD:     rd_data <= 32'((fb_pct * s32(cfg_reg.range)) / pidr_pkg::PCT_FULL);
        pidr_pkg::REG_OUT_PCT:   rd_data <= out_pct_reg;
        default:                 rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  // regulator arithmetic, percentages in 0.01 % steps
  always_comb begin
    set_pct  = set_eff_reg >>> pidr_pkg::FRAC_BITS;
    fb_pct   = fb_filt_reg >>> pidr_pkg::FRAC_BITS;
    dir_rev  = cfg_reg.ctrl[pidr_pkg::CTRL_DIR] ^ sync2_reg.dir_invert;
    err      = dir_rev ? (fb_pct - set_pct) : (set_pct - fb_pct);
    abs_err  = (err < 0) ? -err : err;
    in_dead  = abs_err < s32(cfg_reg.dead) * pidr_pkg::PERMILLE;
    case (cfg_reg.sw_mode)
      pidr_pkg::SW_TERM: begin
        kp = s32(sync2_reg.gain_select ? cfg_reg.kp2 : cfg_reg.kp1);
        ti = s32(sync2_reg.gain_select ? cfg_reg.ti2 : cfg_reg.ti1);
        td = s32(sync2_reg.gain_select ? cfg_reg.td2 : cfg_reg.td1);
      end
      pidr_pkg::SW_AUTO: begin
        if (abs_err < s32(cfg_reg.thr_lo) * pidr_pkg::PERMILLE) begin
          kp = s32(cfg_reg.kp1);
          ti = s32(cfg_reg.ti1);
          td = s32(cfg_reg.td1);
        end else if (abs_err > s32(cfg_reg.thr_hi) * pidr_pkg::PERMILLE) begin
          kp = s32(cfg_reg.kp2);
          ti = s32(cfg_reg.ti2);
          td = s32(cfg_reg.td2);
        end else begin
          kp = lerp(s32(cfg_reg.kp1), s32(cfg_reg.kp2), abs_err,
                    s32(cfg_reg.thr_lo) * pidr_pkg::PERMILLE,
                    s32(cfg_reg.thr_hi) * pidr_pkg::PERMILLE);
          ti = lerp(s32(cfg_reg.ti1), s32(cfg_reg.ti2), abs_err,
                    s32(cfg_reg.thr_lo) * pidr_pkg::PERMILLE,
                    s32(cfg_reg.thr_hi) * pidr_pkg::PERMILLE);
          td = lerp(s32(cfg_reg.td1), s32(cfg_reg.td2), abs_err,
                    s32(cfg_reg.thr_lo) * pidr_pkg::PERMILLE,
                    s32(cfg_reg.thr_hi) * pidr_pkg::PERMILLE);
        end
      end
      default: begin
        kp = s32(cfg_reg.kp1);
        ti = s32(cfg_reg.ti1);
        td = s32(cfg_reg.td1);
      end
    endcase
    if (ti < 32'sh1) begin
      ti = 32'sh1;
    end
    p_term = kp * err / pidr_pkg::KP_FULL;
    // feedback rise acts against the output in forward action
    d_term = (fb_pct - fb_prev_reg) * td
             / $signed(32'(pidr_pkg::TICK_TIME_US / pidr_pkg::US_PER_MS));
    d_term = dir_rev ? d_term : -d_term;
    d_term = clamp(d_term, -s32(cfg_reg.dclamp), s32(cfg_reg.dclamp));
    i_freeze = (cfg_reg.ctrl[pidr_pkg::CTRL_SEP] & sync2_reg.int_pause)
             | (cfg_reg.ctrl[pidr_pkg::CTRL_STOP_LIM] & sat_reg);
    raw  = p_term + (i_reg >>> pidr_pkg::FRAC_BITS) + d_term;
    lim  = clamp(raw, -pidr_pkg::PCT_FULL, pidr_pkg::PCT_FULL);
    step_out = clamp(lim, out_pct_reg - s32(cfg_reg.fall), out_pct_reg + s32(cfg_reg.rise));
    sat_next = (raw != lim) || (lim != step_out);
    if (cfg_reg.ramp == 16'h0) begin
      ramp_step = pidr_pkg::PCT_FULL <<< pidr_pkg::FRAC_BITS;
    end else begin
      ramp_step = (pidr_pkg::PCT_FULL <<< pidr_pkg::FRAC_BITS)
                  / (s32(cfg_reg.ramp) * 32'(pidr_pkg::TICKS_PER_CS));
    end
    set_next = clamp(s32(setting_in), 32'sh0, pidr_pkg::PCT_FULL) <<< pidr_pkg::FRAC_BITS;
    set_next = clamp(set_next, set_eff_reg - ramp_step, set_eff_reg + ramp_step);
    fb_next  = filt(fb_filt_reg,
                    clamp(s32(feedback_in), 32'sh0, pidr_pkg::PCT_FULL) <<< pidr_pkg::FRAC_BITS,
                    cfg_reg.fb_filt);
    out_filt_next = filt(out_filt_reg, out_pct_reg <<< pidr_pkg::FRAC_BITS,
                         cfg_reg.out_filt);
    freq_next = (out_filt_reg >>> pidr_pkg::FRAC_BITS) * s32(cfg_reg.max_freq)
                / pidr_pkg::PCT_FULL;
    rev_lim   = -s32(cfg_reg.rev_cut);
    if (freq_next < rev_lim) begin
      freq_next = rev_lim;
    end
    loss_now = (cfg_reg.loss_lvl != 16'h0)
             && (fb_pct < s32(cfg_reg.loss_lvl) * pidr_pkg::PERMILLE);
    computing = drive_run || cfg_reg.ctrl[pidr_pkg::CTRL_RUN_STOP];
  end

  // setting ramp and feedback filter run on every tick
  always_ff @(posedge clk) begin
    if (srst) begin
      set_eff_reg <= '0;
      fb_filt_reg <= '0;
      fb_prev_reg <= '0;
    end else if (tick) begin
      set_eff_reg <= set_next;
      fb_filt_reg <= fb_next;
      fb_prev_reg <= fb_pct;
    end
  end

  // start hold, loop update and stop handling
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= pidr_pkg::ST_IDLE;
      run_prev_reg <= 1'b0;
      hold_cnt_reg <= '0;
      i_reg        <= '0;
      out_pct_reg  <= '0;
      sat_reg      <= 1'b0;
    end else if (tick) begin
      run_prev_reg <= drive_run;
      if (drive_run && !run_prev_reg) begin
        state_reg    <= pidr_pkg::ST_HOLD;
        hold_cnt_reg <= 32'(cfg_reg.hold) * 32'(pidr_pkg::TICKS_PER_CS);
        out_pct_reg  <= s32(cfg_reg.init) * pidr_pkg::PERMILLE;
        i_reg        <= (s32(cfg_reg.init) * pidr_pkg::PERMILLE) <<< pidr_pkg::FRAC_BITS;
        sat_reg      <= 1'b0;
      end else begin
        case (state_reg)
          pidr_pkg::ST_HOLD: begin
            if (hold_cnt_reg <= 32'h1) begin
              state_reg <= pidr_pkg::ST_RUN;
            end
            if (hold_cnt_reg != 32'h0) begin
              hold_cnt_reg <= hold_cnt_reg - 32'h1;
            end
          end
          pidr_pkg::ST_RUN, pidr_pkg::ST_IDLE: begin
            if (!computing) begin
              state_reg   <= pidr_pkg::ST_IDLE;
              out_pct_reg <= '0;
              i_reg       <= '0;
              sat_reg     <= 1'b0;
            end else if (!in_dead) begin
              state_reg   <= pidr_pkg::ST_RUN;
              out_pct_reg <= step_out;
              sat_reg     <= sat_next;
              if (!i_freeze) begin
                i_reg <= clamp(i_reg + (err <<< pidr_pkg::FRAC_BITS)
                               / (ti * $signed(32'(pidr_pkg::TICKS_PER_CS))),
                               -(pidr_pkg::PCT_FULL <<< pidr_pkg::FRAC_BITS),
                               pidr_pkg::PCT_FULL <<< pidr_pkg::FRAC_BITS);
              end
            end
          end
          default: state_reg <= pidr_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // output filter, frequency scaling and update strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      out_filt_reg <= '0;
      freq_out     <= '0;
      out_valid    <= 1'b0;
    end else begin
      out_valid <= tick;
      if (tick) begin
        out_filt_reg <= out_filt_next;
        freq_out     <= freq_next;
      end
    end
  end

  // feedback loss detection; a new loss beats a software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      loss_cnt_reg        <= '0;
      feedback_loss_fault <= 1'b0;
    end else begin
      if (tick) begin
        if (!loss_now) begin
          loss_cnt_reg <= '0;
        end else if (loss_cnt_reg <= 32'(cfg_reg.loss_time) * 32'(pidr_pkg::TICKS_PER_DS)) begin
          loss_cnt_reg <= loss_cnt_reg + 32'h1;
        end
      end
      if (tick && loss_now
          && loss_cnt_reg >= 32'(cfg_reg.loss_time) * 32'(pidr_pkg::TICKS_PER_DS)) begin
        feedback_loss_fault <= 1'b1;
      end else if (wr_en && addr == pidr_pkg::REG_CTRL && wr_data[pidr_pkg::CTRL_CLR]) begin
        feedback_loss_fault <= 1'b0;
      end
    end
  end

endmodule // pidr_regulator
`default_nettype wire

// ==== test/pidr_regulator_properties.sv ====
// pidr_regulator_properties: port timing checks for the regulator.
// assumes binding into pidr_regulator with the same tick parameter.
`timescale 1ns/1ps
`default_nettype none
module pidr_regulator_properties #(
  parameter int unsigned TICK_CYCLES = pidr_pkg::TICK_CYCLES
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [31:0]       rd_data,
  input wire logic              drive_run,
  input wire logic signed [31:0] freq_out,
  input wire logic              out_valid,
  input wire logic              feedback_loss_fault
);
  logic [31:0] gap_reg, stop_reg;
  logic [15:0] rev_reg, lvl_reg, rng_reg;
  logic        seen_reg, keep_reg;
  wire logic   wr_ctrl = wr_en && addr == pidr_pkg::REG_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    gap_reg  <= (srst || out_valid) ? '0 : gap_reg + 1;
    seen_reg <= !srst && (seen_reg || out_valid);
    stop_reg <= (srst || drive_run || keep_reg) ? '0 : stop_reg + 1;
  end
  // shadow of the configuration that the checks depend on
  always_ff @(posedge clk) begin
    if (srst) begin
      rev_reg  <= pidr_pkg::RST_REVCUT;
      lvl_reg  <= '0;
      rng_reg  <= pidr_pkg::RST_RANGE;
      keep_reg <= 1'b0;
    end else if (wr_en) begin
      if (addr == pidr_pkg::REG_REV_CUT) rev_reg <= wr_data[15:0];
      if (addr == pidr_pkg::REG_LOSS_LVL) lvl_reg <= wr_data[15:0];
      if (addr == pidr_pkg::REG_RANGE) rng_reg <= wr_data[15:0];
      if (wr_ctrl) keep_reg <= wr_data[pidr_pkg::CTRL_RUN_STOP];
    end
  end
  property p_rd_idle; !$past(rd_en) |-> rd_data == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_range; $past(rd_en) && $past(addr) == pidr_pkg::REG_RANGE |-> rd_data == {16'h0, rng_reg}; endproperty
  a_range: assert property (p_range) else $error("range readback");
  property p_period; out_valid && seen_reg |-> gap_reg == TICK_CYCLES - 1; endproperty
  a_period: assert property (p_period) else $error("tick period");
  property p_gap; gap_reg <= TICK_CYCLES + 1; endproperty
  a_gap: assert property (p_gap) else $error("missing tick");
  property p_hold; $changed(freq_out) |-> out_valid || gap_reg < 2 || gap_reg + 3 > TICK_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("output between ticks");
  property p_rev; freq_out >= -$signed({16'h0, rev_reg}); endproperty
  a_rev: assert property (p_rev) else $error("reverse cut-off");
  property p_sticky; feedback_loss_fault && !(wr_ctrl && wr_data[4]) |=> feedback_loss_fault; endproperty
  a_sticky: assert property (p_sticky) else $error("fault dropped");
  property p_off; lvl_reg == '0 && !feedback_loss_fault |=> !feedback_loss_fault; endproperty
  a_off: assert property (p_off) else $error("fault with detection off");
  property p_stop; stop_reg > 3 * TICK_CYCLES |-> freq_out == '0; endproperty
  a_stop: assert property (p_stop) else $error("output at stop");
  c_tick: cover property (out_valid && seen_reg);
  c_fault: cover property ($rose(feedback_loss_fault));
  c_rev: cover property (freq_out == -$signed({16'h0, rev_reg}));
endmodule // pidr_regulator_properties
`default_nettype wire

// ==== test/pidr_regulator_tb.sv ====
// pidr_regulator_tb: self-checking bench for the process regulator.
// assumes a 20-cycle tick so the run stays short.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module pidr_regulator_tb;
  localparam int unsigned TICK_CYCLES = 20;
  logic               clk, srst, wr_en, rd_en, rd_d, drive_run, out_valid, fault;
  logic [7:0]         addr;
  logic [31:0]        wr_data, rd_data, exp_now, exp_q[$];
  logic [15:0]        setting_in, feedback_in;
  logic signed [31:0] freq_out, frz;
  pidr_pkg::pidr_term_s term_in;
  int                 n_mismatch, total_checks, cyc, seed;
  logic [7:0]  ra[11] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h20, 8'h28, 8'h3c, 8'h40, 8'h4c, 8'h5c, 8'h70};
  logic [15:0] rv[11] = '{16'h03e8, 16'h00c8, 16'h00c8, 16'h00c8, 16'h00c8, 16'h000a, 16'h00c8,
                          16'h0320, 16'h0064, 16'h1388, 16'h0000};
  pidr_regulator #(.TICK_CYCLES(TICK_CYCLES)) dut_u (.clk(clk), .srst(srst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .setting_in(setting_in),
    .feedback_in(feedback_in), .drive_run(drive_run), .term_in(term_in), .freq_out(freq_out),
    .out_valid(out_valid), .feedback_loss_fault(fault));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk iff out_valid);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // read results are taken off the queue in the slot after each strobe
  always @(posedge clk) begin
    if (rd_d) begin
      exp_now = exp_q.pop_front();
      `CHK(rd_data, exp_now)
    end
    rd_d <= rd_en;
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {wr_en, rd_en, rd_d, drive_run, addr, wr_data, setting_in, feedback_in, term_in} = '0;
    {n_mismatch, total_checks, cyc} = '0;
    seed = 97;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) rd(ra[i], {16'h0, rv[i]});
    wr(8'h04, 32'h0000_2710);
    drive_run <= 1'b1;
    repeat (3) begin
      setting_in <= 16'($unsigned($random(seed)) % 32'd10001);
      feedback_in <= 16'($unsigned($random(seed)) % 32'd10001);
      wt(3);
      rd(8'h64, {16'h0, setting_in});
      rd(8'h68, {16'h0, feedback_in});
    end
    setting_in <= 16'h1f40;
    feedback_in <= 16'h07d0;
    drive_run <= 1'b0;
    wt(3);
    drive_run <= 1'b1;
    wt(12);
    `CHK(freq_out > 0 && freq_out <= 600, 1'b1)
    term_in <= 3'b100;
    wt(40);
    `CHK(freq_out, -32'sd200)
    wr(8'h00, 32'h0000_0001);
    wt(40);
    `CHK(freq_out > 0, 1'b1)
    wr(8'h24, 32'h0000_03e8);
    wt(3);
    frz = freq_out;
    wt(3);
    `CHK(freq_out, frz)
    term_in <= 3'b000;
    wr(8'h00, 32'h0000_0000);
    wr(8'h54, 32'h0000_0064);
    feedback_in <= 16'h01f4;
    wt(4);
    `CHK(fault, 1'b1)
    feedback_in <= 16'h1388;
    wt(1);
    wr(8'h00, 32'h0000_0010);
    wt(3);
    `CHK(fault, 1'b0)
    drive_run <= 1'b0;
    wt(5);
    `CHK(freq_out, 32'sd0)
    print_verdict();
  end
endmodule // pidr_regulator_tb
bind pidr_regulator pidr_regulator_properties #(.TICK_CYCLES(TICK_CYCLES)) prop_u (.clk(clk),
  .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .drive_run(drive_run), .freq_out(freq_out), .out_valid(out_valid),
  .feedback_loss_fault(feedback_loss_fault));
`default_nettype wire
